// file: dv/opsd_top_sva.sv
// Purpose: Port-level checks for the output PLL sync distribution block
// Assumes: A register write lands at the APB edge where pready is high
// Notes: Shadow copies of writes judge read data and prescaler tick spacing
`timescale 1ns/1ps
module opsd_top_sva
(
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [opsd_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Prescaler tick
    input wire logic prescaler_out
);
    // ==========================================================
    // Shadow registers
    logic [11:0] idx;
    logic mapped;
    logic wr;
    logic chg;
    logic [3:0] ratio_ff;
    logic [2:0] ctl_ff;
    logic [2:0] mask_ff;
    logic hold_ff;
    logic [4:0] gap_ff;
    logic ok_ff;
    logic [1:0] chg_ff;
    // Address decode and change detect
    assign idx = paddr[opsd_pkg::ADDR_W-1:2];
    assign wr = psel && penable && pready && pwrite;
    assign mapped = idx inside {opsd_pkg::IDX_PRESCALER_RATIO, opsd_pkg::IDX_SYNC_CONTROL,
        opsd_pkg::IDX_SYNC_MASKS, opsd_pkg::IDX_PRESCALER_RESET, opsd_pkg::IDX_PHASE_A,
        opsd_pkg::IDX_PHASE_B, opsd_pkg::IDX_STATUS, opsd_pkg::IDX_SYNC_CMD};
    assign chg = hold_ff || (wr && (idx == opsd_pkg::IDX_PRESCALER_RATIO
        || idx == opsd_pkg::IDX_PRESCALER_RESET));
    // Track writes and the spacing of prescaler ticks
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ratio_ff <= 4'h0;
            ctl_ff <= 3'h0;
            mask_ff <= 3'h0;
            hold_ff <= 1'h0;
            gap_ff <= 5'h00;
            ok_ff <= 1'h0;
            chg_ff <= 2'h0;
        end
        else
        begin
            if (wr && idx == opsd_pkg::IDX_PRESCALER_RATIO)
                ratio_ff <= pwdata[3:0];
            if (wr && idx == opsd_pkg::IDX_SYNC_CONTROL)
                ctl_ff <= pwdata[2:0];
            if (wr && idx == opsd_pkg::IDX_SYNC_MASKS)
                mask_ff <= pwdata[2:0];
            if (wr && idx == opsd_pkg::IDX_PRESCALER_RESET)
                hold_ff <= pwdata[opsd_pkg::PRE_RST_BIT];
            if (prescaler_out)
                gap_ff <= 5'h01;
            else if (gap_ff != 5'h1F)
                gap_ff <= gap_ff + 5'h01;
            chg_ff <= {chg_ff[0], chg}; // Covers ticks already in the pipeline
            ok_ff <= (prescaler_out || ok_ff) && !chg && chg_ff == 2'h0;
        end
    end
    // ==========================================================
    // Assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready not one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_decode: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match decode");
    a_err_data: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("refused read returned data");
    a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    a_ratio_back: assert property (
        pready && !pwrite && idx == opsd_pkg::IDX_PRESCALER_RATIO |-> prdata[3:0] == ratio_ff)
        else $error("ratio readback differs");
    a_ctl_back: assert property (
        pready && !pwrite && idx == opsd_pkg::IDX_SYNC_CONTROL |-> prdata[2:0] == ctl_ff)
        else $error("sync control readback differs");
    a_mask_back: assert property (
        pready && !pwrite && idx == opsd_pkg::IDX_SYNC_MASKS |-> prdata[2:0] == mask_ff)
        else $error("mask readback differs");
    a_tick_gap: assert property (
        prescaler_out && ok_ff && ratio_ff inside {[4'h2:4'h3], [4'h5:4'hB]}
        |-> gap_ff == {1'h0, ratio_ff})
        else $error("prescaler tick spacing wrong");
    a_hold_quiet: assert property (hold_ff && $past(hold_ff, 2) |-> !prescaler_out)
        else $error("prescaler ticks while held");
endmodule

bind opsd_top opsd_top_sva i_opsd_top_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .prescaler_out(prescaler_out)
);

// file: dv/opsd_top_tb.sv
// Purpose: Directed bench for the output PLL sync distribution block
// Assumes: APB answers with one wait state; status inputs lag two cycles
// Notes: Each scenario drives the ports and judges the outcome itself
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); \
        end \
    end
module opsd_top_tb;
    // ==========================================================
    // Stimulus and observed signals
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [opsd_pkg::ADDR_W-1:0] paddr = 14'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic pll_calibrated = 1'h0;
    logic pll_locked = 1'h0;
    logic dpll_freq_lock = 1'h0;
    logic dpll_phase_lock = 1'h0;
    logic active_ref = 1'h0;
    logic [opsd_pkg::CH_DIV_W-1:0] ch_a_ratio = 10'h001;
    logic [opsd_pkg::CH_DIV_W-1:0] ch_b_ratio = 10'h001;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic prescaler_out;
    logic channel_a_output;
    logic channel_b_output;
    logic sync_active;
    logic [31:0] rd;
    logic er;
    int failures = 0;
    int cmp_count = 0;
    int hi;
    int tg;
    localparam logic [3:0] CODES [9] = '{4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB};
    localparam logic [1:0] AM [5] = '{opsd_pkg::AUTO_OFF, opsd_pkg::AUTO_FREQ,
        opsd_pkg::AUTO_FREQ, opsd_pkg::AUTO_PHASE, opsd_pkg::AUTO_PHASE};
    localparam logic AI [5] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0};
    localparam int AE [5] = '{0, 1, 0, 1, 0};
    // Clock
    always #20 pclk = ~pclk;
    // Device under test
    opsd_top i_opsd_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pll_calibrated(pll_calibrated), .pll_locked(pll_locked),
        .dpll_freq_lock(dpll_freq_lock), .dpll_phase_lock(dpll_phase_lock),
        .active_ref(active_ref), .ch_a_ratio(ch_a_ratio), .ch_b_ratio(ch_b_ratio),
        .prescaler_out(prescaler_out), .channel_a_output(channel_a_output),
        .channel_b_output(channel_b_output), .sync_active(sync_active)
    );
    // ==========================================================
    // Bus and observation helpers
    task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        if (n == 20)
            failures++;
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    function automatic logic pick(input int s);
        return s == 0 ? sync_active : s == 1 ? channel_a_output : s == 2 ? channel_b_output
            : s == 3 ? prescaler_out : channel_a_output ^ channel_b_output;
    endfunction
    // Counts high samples and toggles of one output, or of the channel A and B XOR, over n cycles
    task automatic watch(input int s, input int n);
        logic prev;
        logic cur;
        hi = 0;
        tg = 0;
        prev = pick(s);
        repeat (n)
        begin
            @(posedge pclk);
            cur = pick(s);
            hi += int'(cur === 1'h1);
            tg += int'(cur !== prev);
            prev = cur;
        end
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_defaults;
        apb(1'h0, opsd_pkg::IDX_PRESCALER_RATIO, 32'h0);
        `CHK(rd[7:0], opsd_pkg::RST_RATIO)
        apb(1'h0, opsd_pkg::IDX_SYNC_CONTROL, 32'h0);
        `CHK(rd[7:0], opsd_pkg::RST_SYNC_CONTROL)
        apb(1'h0, opsd_pkg::IDX_SYNC_MASKS, 32'h0);
        `CHK(rd[7:0], opsd_pkg::RST_SYNC_MASKS)
        apb(1'h0, 12'h400, 32'h0);
        `CHK({er, rd}, {1'h1, 32'h0000_0000})
        $display("test defaults done");
    endtask
    task automatic t_ratio;
        foreach (CODES[i])
        begin
            apb(1'h1, opsd_pkg::IDX_PRESCALER_RATIO, {28'h0, CODES[i]});
            watch(3, 24);
            watch(3, 12 * int'(CODES[i]));
            `CHK(hi, 12)
        end
        apb(1'h1, opsd_pkg::IDX_PRESCALER_RESET, 32'h2);
        apb(1'h1, opsd_pkg::IDX_PRESCALER_RATIO, 32'h2);
        watch(3, 30);
        `CHK(hi, 0)
        apb(1'h1, opsd_pkg::IDX_PRESCALER_RESET, 32'h0);
        watch(3, 4);
        watch(3, 20);
        `CHK(hi, 10)
        $display("test ratio done");
    endtask
    task automatic t_masks;
        watch(0, 30);
        `CHK(hi, 30)
        apb(1'h1, opsd_pkg::IDX_SYNC_MASKS, 32'h1);
        watch(1, 30);
        `CHK(tg != 0, 1'h1)
        watch(2, 30);
        `CHK(tg, 0)
        apb(1'h1, opsd_pkg::IDX_SYNC_MASKS, 32'h2);
        watch(2, 30);
        `CHK(tg != 0, 1'h1)
        apb(1'h1, opsd_pkg::IDX_SYNC_MASKS, 32'h0);
        $display("test masks done");
    endtask
    task automatic t_sync;
        pll_calibrated <= 1'h1;
        pll_locked <= 1'h1;
        watch(0, 10);
        watch(0, 10);
        `CHK(hi, 0)
        apb(1'h1, opsd_pkg::IDX_SYNC_CMD, 32'h1);
        watch(0, 10);
        `CHK(hi, 1)
        watch(4, 40);
        `CHK(hi, 0)
        apb(1'h1, opsd_pkg::IDX_PHASE_A, 32'h2);
        apb(1'h1, opsd_pkg::IDX_SYNC_CMD, 32'h1);
        watch(0, 10);
        watch(4, 40);
        `CHK(hi != 0, 1'h1)
        apb(1'h1, opsd_pkg::IDX_PHASE_A, 32'h0);
        apb(1'h1, opsd_pkg::IDX_SYNC_CONTROL, 32'h4);
        apb(1'h1, opsd_pkg::IDX_SYNC_CMD, 32'h1);
        watch(0, 20);
        `CHK(hi, 0)
        active_ref <= 1'h1;
        watch(0, 10);
        `CHK(hi, 1)
        active_ref <= 1'h0;
        $display("test sync done");
    endtask
    task automatic t_auto;
        foreach (AM[i])
        begin
            apb(1'h1, opsd_pkg::IDX_SYNC_CONTROL, {30'h0, AM[i]});
            dpll_freq_lock <= !AI[i];
            dpll_phase_lock <= AI[i];
            watch(0, 12);
            `CHK(hi, AE[i])
            dpll_freq_lock <= 1'h0;
            dpll_phase_lock <= 1'h0;
            watch(0, 6);
        end
        $display("test auto done");
    endtask
    task automatic t_override;
        pll_locked <= 1'h0;
        watch(0, 10);
        watch(0, 10);
        `CHK(hi, 10)
        apb(1'h1, opsd_pkg::IDX_SYNC_MASKS, 32'h4);
        watch(0, 10);
        watch(0, 10);
        `CHK(hi, 0)
        apb(1'h1, opsd_pkg::IDX_SYNC_CMD, 32'h1);
        watch(0, 10);
        `CHK(hi, 1)
        $display("test override done");
    endtask
    // ==========================================================
    // Verdict, main sequence and watchdog
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        t_defaults();
        t_ratio();
        t_masks();
        t_sync();
        t_auto();
        t_override();
        conclude();
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        failures++;
        conclude();
    end
endmodule

// file: hdl/opsd_channel_div.sv
// Purpose: One channel divider with sync reset, mask and initial phase
// Assumes: Advances on prescaler ticks; phase counts half input periods
// Notes: Masked channel free-runs and ignores sync
`timescale 1ns/1ps
module opsd_channel_div #(
    parameter int DIV_W = 10
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic tick,
    input wire logic sync_hold,
    input wire logic mask,
    input wire logic [5:0] phase,
    input wire logic [DIV_W-1:0] div_ratio,
    // Output
    output logic clk_out
);
    logic [DIV_W+1:0] half_ff;
    logic [DIV_W+1:0] nxt_half;
    logic out_ff;
    logic nxt_out;
    logic [DIV_W+1:0] period_halves;

    // Full period in half input periods, spare bit so the largest ratio fits
    assign period_halves = {1'b0, div_ratio, 1'b0} + {{DIV_W{1'b0}}, 2'b10};

    // ==========================================================
    // Half-period counter next state
    always_comb
    begin
        nxt_half = half_ff;
        nxt_out = out_ff;
        if (sync_hold && !mask)
        begin
            // Static sync state, loaded with the initial phase
            nxt_half = {{(DIV_W-4){1'b0}}, phase};
            nxt_out = 1'b0;
        end
        else if (tick)
        begin
            // Two half periods per input tick
            if (half_ff + 2'd2 >= period_halves)
            begin
                nxt_half = half_ff + 2'd2 - period_halves;
            end
            else
            begin
                nxt_half = half_ff + 2'd2;
            end
            nxt_out = (nxt_half < {2'b00, div_ratio} + 1'b1);
        end
    end

    // Divider registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            half_ff <= '0;
            out_ff <= 1'b0;
        end
        else
        begin
            half_ff <= nxt_half;
            out_ff <= nxt_out;
        end
    end

    assign clk_out = out_ff;
endmodule

// file: hdl/opsd_pkg.sv
// Purpose: Shared constants for the output PLL sync and distribution block
// Assumes: APB register bus, 32-bit data, printed offsets are register indices
// Notes: Byte address of each register is four times its index
package opsd_pkg;
    // ==========================================================
    // Register indices and byte address width
    localparam logic [11:0] IDX_PRESCALER_RATIO = 12'h434;
    localparam logic [11:0] IDX_SYNC_CONTROL = 12'h435;
    localparam logic [11:0] IDX_SYNC_MASKS = 12'h436;
    localparam logic [11:0] IDX_PRESCALER_RESET = 12'h433;
    localparam logic [11:0] IDX_PHASE_A = 12'h43A;
    localparam logic [11:0] IDX_PHASE_B = 12'h43E;
    localparam logic [11:0] IDX_STATUS = 12'h4F0;
    localparam logic [11:0] IDX_SYNC_CMD = 12'h4F1;
    localparam int ADDR_W = 14;
    // ==========================================================
    // Field positions
    localparam int RATIO_LSB = 0;
    localparam int RATIO_W = 4;
    localparam int SRC_SEL_BIT = 2;
    localparam int AUTO_LSB = 0;
    localparam int AUTO_W = 2;
    localparam int LOCK_OVR_BIT = 2;
    localparam int MASK_B_BIT = 1;
    localparam int MASK_A_BIT = 0;
    localparam int PRE_RST_BIT = 1;
    localparam int PHASE_W = 6;
    localparam int CMD_SYNC_BIT = 0;
    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_RATIO = 8'h00;
    localparam logic [7:0] RST_SYNC_CONTROL = 8'h00;
    localparam logic [7:0] RST_SYNC_MASKS = 8'h00;
    localparam logic [7:0] RST_PRE_RESET = 8'h00;
    localparam logic [5:0] RST_PHASE = 6'h00;
    // ==========================================================
    // Automatic sync modes
    localparam logic [1:0] AUTO_OFF = 2'h0;
    localparam logic [1:0] AUTO_FREQ = 2'h1;
    localparam logic [1:0] AUTO_PHASE = 2'h2;
    // Divider widths
    localparam int CH_DIV_W = 10;
endpackage

// file: hdl/opsd_prescaler.sv
// Purpose: Integer prescaler that divides the output PLL clock
// Assumes: Runs in the pclk domain; ratio codes 0 and 1 are undefined
// Notes: Emits a one-cycle tick per divided period
`timescale 1ns/1ps
module opsd_prescaler
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic hold,
    input wire logic [3:0] ratio,
    // Divided output
    output logic tick
);
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic tick_ff;
    logic nxt_tick;

    // ==========================================================
    // Counter next state
    always_comb
    begin
        nxt_cnt = cnt_ff + 4'h1;
        nxt_tick = 1'b0;
        if (hold)
        begin
            nxt_cnt = 4'h0;
        end
        else if (cnt_ff + 4'h1 >= ratio)
        begin
            nxt_cnt = 4'h0;
            nxt_tick = 1'b1;
        end
    end

    // Counter registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_ff <= 4'h0;
            tick_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;
endmodule

// file: hdl/opsd_top.sv
// Purpose: Output PLL prescaler, sync source and channel sync control
// Assumes: APB slave, 32-bit data, one clock pclk; status pins are async
// Notes: Register byte address is four times the register index
`timescale 1ns/1ps
// Summary of operation
// - The prescaler divides the PLL clock by the integer ratio in the low four ratio bits.
// - With the source bit clear the sync pulse is gated only by calibration and lock.
// - With the source bit set the sync pulse waits for the next active reference edge.
// - Auto sync field: 00 off, 01 on frequency lock, 10 on phase lock, 11 reserved.
// - With the lock override clear, sync waits until the PLL is calibrated and locked.
// - With the lock override set, sync is driven by the controls whatever the lock state.
// - Setting the channel B mask releases its divider at once so it toggles freely.
// - A masked channel B ignores all sync and does not gain driver enable.
// - Setting the channel A mask releases its divider at once so it toggles freely.
// - A masked channel A ignores all sync and does not gain driver enable.
// - Prescaler reset holds the prescaler while 1 and lets it run while 0.
// - After sync each divider starts at its programmed phase in half input periods.
module opsd_top #(
    parameter int CH_DIV_W = opsd_pkg::CH_DIV_W
)
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [opsd_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Asynchronous status from PLL and DPLL
    input wire logic pll_calibrated,
    input wire logic pll_locked,
    input wire logic dpll_freq_lock,
    input wire logic dpll_phase_lock,
    input wire logic active_ref,
    // Channel ratios from elsewhere
    input wire logic [CH_DIV_W-1:0] ch_a_ratio,
    input wire logic [CH_DIV_W-1:0] ch_b_ratio,
    // Outputs
    output logic prescaler_out,
    output logic channel_a_output,
    output logic channel_b_output,
    output logic sync_active
);
    // ==========================================================
    // Registers
    logic [7:0] ratio_ff, nxt_ratio;
    logic [7:0] sync_ctl_ff, nxt_sync_ctl;
    logic [7:0] masks_ff, nxt_masks;
    logic [7:0] pre_rst_ff, nxt_pre_rst;
    logic [5:0] phase_a_ff, nxt_phase_a;
    logic [5:0] phase_b_ff, nxt_phase_b;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic sw_sync;

    // Synchronisers for async inputs
    logic [4:0] s1_ff, s2_ff;
    logic ref_d_ff;
    logic freq_d_ff;
    logic phase_d_ff;

    // Sync state machine
    typedef enum logic [1:0] {ST_WAIT_PLL, ST_IDLE, ST_WAIT_REF, ST_HOLD} opsd_state_t;
    opsd_state_t state_ff, nxt_state;
    logic hold_ff, nxt_hold;
    logic pre_out_ff;

    logic wr_acc, rd_acc, acc;
    logic [11:0] idx;
    logic pll_ready, ref_edge, auto_trig, trig;
    logic pre_tick, ch_a_clk, ch_b_clk;

    // Register index decode
    function automatic logic idx_known(input logic [11:0] i);
        idx_known = (i == opsd_pkg::IDX_PRESCALER_RATIO) || (i == opsd_pkg::IDX_SYNC_CONTROL) ||
                    (i == opsd_pkg::IDX_SYNC_MASKS) || (i == opsd_pkg::IDX_PRESCALER_RESET) ||
                    (i == opsd_pkg::IDX_PHASE_A) || (i == opsd_pkg::IDX_PHASE_B) ||
                    (i == opsd_pkg::IDX_STATUS) || (i == opsd_pkg::IDX_SYNC_CMD);
    endfunction

    // ==========================================================
    // APB decode: one wait state; a write lands at the edge that sees pready
    assign acc = psel && penable && !pready_ff;
    assign wr_acc = psel && penable && pready_ff && pwrite && idx_known(idx);
    assign rd_acc = acc && !pwrite;
    assign idx = paddr[opsd_pkg::ADDR_W-1:2];
    assign sw_sync = wr_acc && (idx == opsd_pkg::IDX_SYNC_CMD) && pwdata[opsd_pkg::CMD_SYNC_BIT];

    // Register next values
    always_comb
    begin
        nxt_ratio = ratio_ff;
        nxt_sync_ctl = sync_ctl_ff;
        nxt_masks = masks_ff;
        nxt_pre_rst = pre_rst_ff;
        nxt_phase_a = phase_a_ff;
        nxt_phase_b = phase_b_ff;
        nxt_pready = acc;
        nxt_pslverr = acc && !idx_known(idx);
        nxt_prdata = 32'h0000_0000;
        if (wr_acc)
        begin
            case (idx)
                opsd_pkg::IDX_PRESCALER_RATIO: nxt_ratio = {4'h0, pwdata[3:0]};
                opsd_pkg::IDX_SYNC_CONTROL: nxt_sync_ctl = {5'h00, pwdata[2:0]};
                opsd_pkg::IDX_SYNC_MASKS: nxt_masks = {5'h00, pwdata[2:0]};
                opsd_pkg::IDX_PRESCALER_RESET: nxt_pre_rst = {6'h00, pwdata[1], 1'b0};
                opsd_pkg::IDX_PHASE_A: nxt_phase_a = pwdata[5:0];
                opsd_pkg::IDX_PHASE_B: nxt_phase_b = pwdata[5:0];
                default: nxt_ratio = ratio_ff;
            endcase
        end
        if (rd_acc)
        begin
            case (idx)
                opsd_pkg::IDX_PRESCALER_RATIO: nxt_prdata = {24'h000000, ratio_ff};
                opsd_pkg::IDX_SYNC_CONTROL: nxt_prdata = {24'h000000, sync_ctl_ff};
                opsd_pkg::IDX_SYNC_MASKS: nxt_prdata = {24'h000000, masks_ff};
                opsd_pkg::IDX_PRESCALER_RESET: nxt_prdata = {24'h000000, pre_rst_ff};
                opsd_pkg::IDX_PHASE_A: nxt_prdata = {26'h0000000, phase_a_ff};
                opsd_pkg::IDX_PHASE_B: nxt_prdata = {26'h0000000, phase_b_ff};
                opsd_pkg::IDX_STATUS: nxt_prdata = {25'h0000000, state_ff, hold_ff, s2_ff[3:0]};
                default: nxt_prdata = 32'h0000_0000;
            endcase
        end
    end

    // Register file
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ratio_ff <= opsd_pkg::RST_RATIO;
            sync_ctl_ff <= opsd_pkg::RST_SYNC_CONTROL;
            masks_ff <= opsd_pkg::RST_SYNC_MASKS;
            pre_rst_ff <= opsd_pkg::RST_PRE_RESET;
            phase_a_ff <= opsd_pkg::RST_PHASE;
            phase_b_ff <= opsd_pkg::RST_PHASE;
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            ratio_ff <= nxt_ratio;
            sync_ctl_ff <= nxt_sync_ctl;
            masks_ff <= nxt_masks;
            pre_rst_ff <= nxt_pre_rst;
            phase_a_ff <= nxt_phase_a;
            phase_b_ff <= nxt_phase_b;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // ==========================================================
    // Two-flop synchronisers, then edge history from the second flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_ff <= 5'h00;
            s2_ff <= 5'h00;
            ref_d_ff <= 1'b0;
            freq_d_ff <= 1'b0;
            phase_d_ff <= 1'b0;
        end
        else
        begin
            s1_ff <= {active_ref, dpll_phase_lock, dpll_freq_lock, pll_locked, pll_calibrated};
            s2_ff <= s1_ff;
            ref_d_ff <= s2_ff[4];
            freq_d_ff <= s2_ff[2];
            phase_d_ff <= s2_ff[3];
        end
    end

    // calibrate and lock gate; lock override bypasses it
    assign pll_ready = (s2_ff[0] && s2_ff[1]) || masks_ff[opsd_pkg::LOCK_OVR_BIT];
    assign ref_edge = s2_ff[4] && !ref_d_ff;

    // auto sync trigger on lock rising edge
    always_comb
    begin
        case (sync_ctl_ff[opsd_pkg::AUTO_LSB +: opsd_pkg::AUTO_W])
            opsd_pkg::AUTO_FREQ: auto_trig = s2_ff[2] && !freq_d_ff;
            opsd_pkg::AUTO_PHASE: auto_trig = s2_ff[3] && !phase_d_ff;
            default: auto_trig = 1'b0;
        endcase
    end
    assign trig = auto_trig || sw_sync;

    // ==========================================================
    // Sync sequencer next state
    always_comb
    begin
        nxt_state = state_ff;
        nxt_hold = hold_ff;
        case (state_ff)
            ST_WAIT_PLL:
            begin
                // dividers stay in sync until armed
                nxt_hold = 1'b1;
                if (pll_ready)
                begin
                    nxt_state = ST_IDLE;
                    nxt_hold = 1'b0;
                end
            end
            ST_IDLE:
            begin
                nxt_hold = 1'b0;
                if (!pll_ready)
                begin
                    nxt_state = ST_WAIT_PLL;
                    nxt_hold = 1'b1;
                end
                else if (trig && sync_ctl_ff[opsd_pkg::SRC_SEL_BIT])
                begin
                    nxt_state = ST_WAIT_REF;
                end
                else if (trig)
                begin
                    nxt_state = ST_HOLD;
                    nxt_hold = 1'b1;
                end
            end
            ST_WAIT_REF:
            begin
                if (ref_edge)
                begin
                    nxt_state = ST_HOLD;
                    nxt_hold = 1'b1;
                end
            end
            ST_HOLD:
            begin
                nxt_state = ST_IDLE;
                nxt_hold = 1'b0;
            end
            default:
            begin
                nxt_state = ST_WAIT_PLL;
                nxt_hold = 1'b1;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= ST_WAIT_PLL;
            hold_ff <= 1'b1;
            pre_out_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            hold_ff <= nxt_hold;
            pre_out_ff <= pre_tick;
        end
    end

    // ==========================================================
    // prescaler; held by prescaler reset
    opsd_prescaler u_pre
    (
        .pclk(pclk),
        .presetn(presetn),
        .hold(pre_rst_ff[opsd_pkg::PRE_RST_BIT]),
        .ratio(ratio_ff[opsd_pkg::RATIO_LSB +: opsd_pkg::RATIO_W]),
        .tick(pre_tick)
    );

    // common sync hold; phase; channel A mask
    opsd_channel_div #(.DIV_W(CH_DIV_W)) u_ch_a
    (
        .pclk(pclk),
        .presetn(presetn),
        .tick(pre_tick),
        .sync_hold(hold_ff),
        .mask(masks_ff[opsd_pkg::MASK_A_BIT]),
        .phase(phase_a_ff),
        .div_ratio(ch_a_ratio),
        .clk_out(ch_a_clk)
    );

    opsd_channel_div #(.DIV_W(CH_DIV_W)) u_ch_b
    (
        .pclk(pclk),
        .presetn(presetn),
        .tick(pre_tick),
        .sync_hold(hold_ff),
        .mask(masks_ff[opsd_pkg::MASK_B_BIT]),
        .phase(phase_b_ff),
        .div_ratio(ch_b_ratio),
        .clk_out(ch_b_clk)
    );

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign prescaler_out = pre_out_ff;
    assign channel_a_output = ch_a_clk;
    assign channel_b_output = ch_b_clk;
    assign sync_active = hold_ff;
endmodule
